// *** src/dstr_regs.sv ***
// control and status register bank of the audio decoder
// assumes a control-bus front end that delivers byte reads and writes,
// and a decoding core that reports sync, frames, bitrate and boot
`timescale 1ns/100ps
`include "dstr_defines.svh"

module dstr_regs import dstr_pkg::*; #(
  parameter logic [7:0] FW_REVISION = 8'h01, // arbitrary value
  parameter int RATE_WIDTH = 12
) (
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic sw_reset,
  // register port from the control-bus front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // decoding core status
  input wire logic core_sync,
  input wire logic [15:0] core_fraction,
  input wire logic core_family_48k,
  input wire logic frame_done,
  input wire logic [RATE_WIDTH-1:0] core_rate_x16,
  input wire logic boot_done,
  // controls toward the core and the clock synthesiser
  output logic decode_run,
  output logic [15:0] synth_fraction,
  output logic synth_fraction_active,
  output logic [15:0] high_shelf_corner,
  output logic [15:0] low_shelf_corner,
  output logic [7:0] high_shelf_steps,
  output logic [7:0] low_shelf_steps
);

  // refuse widths that the rounding slice cannot serve
  if (RATE_WIDTH < `DSTR_RATE_FRAC_BITS + 8 ||
      RATE_WIDTH > `DSTR_RATE_WIDTH_MAX) begin : g_rate_width_check
    $error("dstr_regs: RATE_WIDTH must be 12 to 16");
  end

  // address decode
  // writes to read-only or unmapped offsets hit nothing and are dropped
  logic hit_frac_lo;
  logic hit_frac_hi;
  logic hit_go;
  logic hit_hc_lo;
  logic hit_hc_hi;
  logic hit_lc_lo;
  logic hit_lc_hi;
  logic hit_hg;
  logic hit_lg;

  assign hit_frac_lo = reg_addr == `DSTR_OFS_FRAC_LOW;
  assign hit_frac_hi = reg_addr == `DSTR_OFS_FRAC_HIGH;
  assign hit_go = reg_addr == `DSTR_OFS_DECODE_GO;
  assign hit_hc_lo = reg_addr == `DSTR_OFS_HI_CORNER_LOW;
  assign hit_hc_hi = reg_addr == `DSTR_OFS_HI_CORNER_HIGH;
  assign hit_lc_lo = reg_addr == `DSTR_OFS_LO_CORNER_LOW;
  assign hit_lc_hi = reg_addr == `DSTR_OFS_LO_CORNER_HIGH;
  assign hit_hg = reg_addr == `DSTR_OFS_HI_GAIN;
  assign hit_lg = reg_addr == `DSTR_OFS_LO_GAIN;

  // stored registers
  dstr_byte_t synth_fraction_low;
  dstr_byte_t synth_fraction_high;
  dstr_byte_t high_shelf_corner_low;
  dstr_byte_t high_shelf_corner_high;
  dstr_byte_t low_shelf_corner_low;
  dstr_byte_t low_shelf_corner_high;
  dstr_byte_t high_shelf_gain;
  dstr_byte_t low_shelf_gain;
  dstr_byte_t mean_stream_rate;
  logic booted;
  dstr_run_state_t run_state;

  // fraction: the core load wins over a host write in the same cycle,
  // so the tracked setting is never overwritten by a stale host value
  dstr_byte_t next_frac_lo;
  dstr_byte_t next_frac_hi;

  assign next_frac_lo = sw_reset ? `DSTR_SRST_FRAC_LOW :
                        core_sync ? core_fraction[`DSTR_BYTE_LO] :
                        (reg_wr && hit_frac_lo) ? reg_wdata :
                        synth_fraction_low;
  assign next_frac_hi = sw_reset ? `DSTR_RST_FRAC_HIGH :
                        core_sync ? core_fraction[`DSTR_BYTE_HI] :
                        (reg_wr && hit_frac_hi) ? reg_wdata :
                        synth_fraction_high;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // hardware reset value of the low byte is undefined; zero is used
      synth_fraction_low <= `DSTR_HRST_FRAC_LOW;
      synth_fraction_high <= `DSTR_RST_FRAC_HIGH;
    end else begin
      synth_fraction_low <= next_frac_lo;
      synth_fraction_high <= next_frac_hi;
    end
  end

  // concatenated value feeding the synthesiser fraction term
  assign synth_fraction = {synth_fraction_high, synth_fraction_low};

  // this fraction only drives the 48/32 kHz family of rates; the flag is
  // registered so the synthesiser never sees a glitch from the core side
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      synth_fraction_active <= 1'b0;
    end else begin
      synth_fraction_active <= core_family_48k;
    end
  end

  // tone control bytes: host writable, cleared by either reset
  dstr_byte_t next_hc_lo;
  dstr_byte_t next_hc_hi;
  dstr_byte_t next_lc_lo;
  dstr_byte_t next_lc_hi;
  dstr_byte_t next_hg;
  dstr_byte_t next_lg;

  assign next_hc_lo = sw_reset ? `DSTR_RST_BYTE :
                      (reg_wr && hit_hc_lo) ? reg_wdata :
                      high_shelf_corner_low;
  assign next_hc_hi = sw_reset ? `DSTR_RST_BYTE :
                      (reg_wr && hit_hc_hi) ? reg_wdata :
                      high_shelf_corner_high;
  assign next_lc_lo = sw_reset ? `DSTR_RST_BYTE :
                      (reg_wr && hit_lc_lo) ? reg_wdata :
                      low_shelf_corner_low;
  assign next_lc_hi = sw_reset ? `DSTR_RST_BYTE :
                      (reg_wr && hit_lc_hi) ? reg_wdata :
                      low_shelf_corner_high;
  assign next_hg = sw_reset ? `DSTR_RST_BYTE :
                   (reg_wr && hit_hg) ? reg_wdata :
                   high_shelf_gain;
  assign next_lg = sw_reset ? `DSTR_RST_BYTE :
                   (reg_wr && hit_lg) ? reg_wdata :
                   low_shelf_gain;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_shelf_corner_low <= `DSTR_RST_BYTE;
      high_shelf_corner_high <= `DSTR_RST_BYTE;
      low_shelf_corner_low <= `DSTR_RST_BYTE;
      low_shelf_corner_high <= `DSTR_RST_BYTE;
      high_shelf_gain <= `DSTR_RST_BYTE;
      low_shelf_gain <= `DSTR_RST_BYTE;
    end else begin
      high_shelf_corner_low <= next_hc_lo;
      high_shelf_corner_high <= next_hc_hi;
      low_shelf_corner_low <= next_lc_lo;
      low_shelf_corner_high <= next_lc_hi;
      high_shelf_gain <= next_hg;
      low_shelf_gain <= next_lg;
    end
  end

  // corner limits are the host's to keep; the bank passes them unchecked
  assign high_shelf_corner = {high_shelf_corner_high,
                              high_shelf_corner_low};
  assign low_shelf_corner = {low_shelf_corner_high,
                             low_shelf_corner_low};

  // gain steps toward the filter, clamped and registered
  logic [7:0] hg_clamped;
  logic [7:0] lg_clamped;

  dstr_gain_sat u_hg_sat (
    .raw(high_shelf_gain),
    .clamped(hg_clamped)
  );

  dstr_gain_sat u_lg_sat (
    .raw(low_shelf_gain),
    .clamped(lg_clamped)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_shelf_steps <= `DSTR_RST_BYTE;
      low_shelf_steps <= `DSTR_RST_BYTE;
    end else begin
      high_shelf_steps <= hg_clamped;
      low_shelf_steps <= lg_clamped;
    end
  end

  // run flag: a write of 1 leaves idle; the host orders its setup first
  logic go_write;
  dstr_run_state_t next_run_state;

  assign go_write = reg_wr && hit_go;

  always_comb begin
    next_run_state = run_state;
    case (run_state)
      DSTR_IDLE: begin
        if (go_write && reg_wdata[`DSTR_GO_BIT]) begin
          next_run_state = DSTR_DECODING;
        end
      end
      DSTR_DECODING: begin
        if (go_write && !reg_wdata[`DSTR_GO_BIT]) begin
          next_run_state = DSTR_IDLE;
        end
      end
      default: begin
        next_run_state = DSTR_IDLE;
      end
    endcase
    if (sw_reset) begin
      next_run_state = DSTR_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_state <= DSTR_IDLE;
    end else begin
      run_state <= next_run_state;
    end
  end

  assign decode_run = run_state == DSTR_DECODING;

  // frame counter
  logic [`DSTR_FRAMES_WIDTH-1:0] frame_count;

  dstr_frame_counter #(
    .WIDTH(`DSTR_FRAMES_WIDTH)
  ) u_frames (
    .mclk(mclk),
    .rst(rst),
    .sw_reset(sw_reset),
    .frame_done(frame_done),
    .count(frame_count)
  );

  // mean bitrate: round the fixed-point core figure to whole kbit/s
  logic [RATE_WIDTH:0] rate_sum;
  logic [RATE_WIDTH-`DSTR_RATE_FRAC_BITS:0] rate_whole;
  logic rate_over;
  dstr_byte_t next_rate;

  assign rate_sum = {1'b0, core_rate_x16} +
                    (RATE_WIDTH+1)'(`DSTR_RATE_HALF);
  assign rate_whole = rate_sum[RATE_WIDTH:`DSTR_RATE_FRAC_BITS];
  // a byte tops out at 255 kbit/s; higher rates read as the maximum
  assign rate_over = rate_whole >
                     (RATE_WIDTH-`DSTR_RATE_FRAC_BITS+1)'(`DSTR_RATE_MAX);
  assign next_rate = sw_reset ? `DSTR_RST_BYTE :
                     rate_over ? `DSTR_RATE_MAX :
                     rate_whole[`DSTR_BYTE_LO];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mean_stream_rate <= `DSTR_RST_BYTE;
    end else begin
      mean_stream_rate <= next_rate;
    end
  end

  // boot flag: sticky once the embedded software is up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      booted <= 1'b0;
    end else begin
      booted <= booted || boot_done;
    end
  end

  // read mux
  dstr_byte_t read_sel;
  dstr_byte_t firmware_revision;
  dstr_byte_t go_readback;

  assign firmware_revision = booted ? FW_REVISION : `DSTR_RST_BYTE;

  // go reads back the live run state, not the last byte written
  assign go_readback = dstr_byte_t'(decode_run) << `DSTR_GO_BIT;

  always_comb begin
    case (reg_addr)
      `DSTR_OFS_FRAC_LOW: read_sel = synth_fraction_low;
      `DSTR_OFS_FRAC_HIGH: read_sel = synth_fraction_high;
      `DSTR_OFS_FRAMES_B0: read_sel = frame_count[`DSTR_BYTE_LO];
      `DSTR_OFS_FRAMES_B1: read_sel = frame_count[`DSTR_BYTE_HI];
      `DSTR_OFS_FRAMES_B2: read_sel = frame_count[`DSTR_FRAMES_TOP];
      `DSTR_OFS_MEAN_RATE: read_sel = mean_stream_rate;
      `DSTR_OFS_FW_REV: read_sel = firmware_revision;
      `DSTR_OFS_DECODE_GO: read_sel = go_readback;
      `DSTR_OFS_HI_CORNER_LOW: read_sel = high_shelf_corner_low;
      `DSTR_OFS_HI_CORNER_HIGH: read_sel = high_shelf_corner_high;
      `DSTR_OFS_LO_CORNER_LOW: read_sel = low_shelf_corner_low;
      `DSTR_OFS_LO_CORNER_HIGH: read_sel = low_shelf_corner_high;
      `DSTR_OFS_HI_GAIN: read_sel = high_shelf_gain;
      `DSTR_OFS_LO_GAIN: read_sel = low_shelf_gain;
      default: read_sel = `DSTR_UNMAPPED_READ;
    endcase
  end

  // read data registered one cycle after the strobe
  // rdata holds between reads, so a slow host may still take it late
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `DSTR_RST_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= read_sel;
      end
    end
  end

endmodule // dstr_regs

// *** src/dstr_defines.svh ***
// register offsets, reset values and limits of the decoder status/tone bank
// assumes an 8-bit register address space seen through the control port
`ifndef DSTR_DEFINES_SVH
`define DSTR_DEFINES_SVH

// register offsets
`define DSTR_OFS_FRAC_LOW 8'h64
`define DSTR_OFS_FRAC_HIGH 8'h65
`define DSTR_OFS_FRAMES_B0 8'h67
`define DSTR_OFS_FRAMES_B1 8'h68
`define DSTR_OFS_FRAMES_B2 8'h69
`define DSTR_OFS_MEAN_RATE 8'h6A
`define DSTR_OFS_FW_REV 8'h71
`define DSTR_OFS_DECODE_GO 8'h72
`define DSTR_OFS_HI_CORNER_LOW 8'h77
`define DSTR_OFS_HI_CORNER_HIGH 8'h78
`define DSTR_OFS_LO_CORNER_LOW 8'h79
`define DSTR_OFS_LO_CORNER_HIGH 8'h7A
`define DSTR_OFS_HI_GAIN 8'h7B
`define DSTR_OFS_LO_GAIN 8'h7C

// reset values
`define DSTR_HRST_FRAC_LOW 8'h00
`define DSTR_SRST_FRAC_LOW 8'h46
`define DSTR_RST_FRAC_HIGH 8'h5B
`define DSTR_RST_BYTE 8'h00
`define DSTR_RST_FRAMES 24'h000000
`define DSTR_UNMAPPED_READ 8'h00

// field positions
`define DSTR_GO_BIT 0
`define DSTR_BYTE_HI 15:8
`define DSTR_BYTE_LO 7:0
`define DSTR_FRAMES_TOP 23:16
`define DSTR_FRAMES_WIDTH 24

// gain limit in 1.5 dB steps
`define DSTR_GAIN_MAX 8'h0C
`define DSTR_GAIN_MIN 8'hF4

// rate input carries 4 fraction bits; half a unit for rounding
`define DSTR_RATE_FRAC_BITS 4
`define DSTR_RATE_HALF 12'h008
`define DSTR_RATE_MAX 8'hFF
`define DSTR_RATE_WIDTH_MAX 16

`endif

// *** src/dstr_pkg.sv ***
// types shared by the decoder status/tone register bank
// assumes the defines header for every numeric constant
package dstr_pkg;

  typedef logic [7:0] dstr_byte_t;

  typedef enum logic [0:0] {
    DSTR_IDLE,
    DSTR_DECODING
  } dstr_run_state_t;

endpackage

// *** src/dstr_frame_counter.sv ***
// 24-bit decoded-frame counter, cleared by hardware and software reset
// assumes frame_done is a one-cycle pulse per decoded frame
`timescale 1ns/100ps
`include "dstr_defines.svh"

module dstr_frame_counter import dstr_pkg::*; #(
  parameter int WIDTH = 24
) (
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic sw_reset,
  // events
  input wire logic frame_done,
  // count
  output logic [WIDTH-1:0] count
);

  // the register map exposes exactly three count bytes
  if (WIDTH != `DSTR_FRAMES_WIDTH) begin : g_width_check
    $error("dstr_frame_counter: register map needs WIDTH of 24");
  end

  logic [WIDTH-1:0] next_count;

  // soft reset wins over a frame in the same cycle
  assign next_count = sw_reset ? `DSTR_RST_FRAMES :
                      frame_done ? count + 1'b1 : count;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= `DSTR_RST_FRAMES;
    end else begin
      count <= next_count;
    end
  end

endmodule // dstr_frame_counter

// *** src/dstr_gain_sat.sv ***
// clamps a signed gain byte to the allowed step range
// combinational; the caller registers the result
`timescale 1ns/100ps
`include "dstr_defines.svh"

module dstr_gain_sat import dstr_pkg::*; (
  // raw gain as written by the host
  input wire logic [7:0] raw,
  // clamped gain
  output logic [7:0] clamped
);

  logic signed [7:0] raw_s;
  logic signed [7:0] lim_hi;
  logic signed [7:0] lim_lo;
  logic over;
  logic under;

  assign raw_s = signed'(raw);
  assign lim_hi = signed'(`DSTR_GAIN_MAX);
  assign lim_lo = signed'(`DSTR_GAIN_MIN);
  assign over = raw_s > lim_hi;
  assign under = raw_s < lim_lo;
  // saturate instead of wrapping so a wild value cannot flip boost to cut
  assign clamped = over ? `DSTR_GAIN_MAX :
                   under ? `DSTR_GAIN_MIN : raw;

endmodule // dstr_gain_sat

// *** testbench/dstr_regs_properties.sv ***
// assertions on the ports of the decoder status/tone register bank
// assumes one mclk domain with rst as asynchronous reset
`timescale 1ns/100ps
module dstr_regs_properties (
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic sw_reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  // core side
  input wire logic core_sync,
  input wire logic [15:0] core_fraction,
  input wire logic core_family_48k,
  // controls
  input wire logic decode_run,
  input wire logic [15:0] synth_fraction,
  input wire logic synth_fraction_active,
  input wire logic [15:0] high_shelf_corner,
  input wire logic [7:0] high_shelf_steps
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_go_wr;
    reg_wr && reg_addr == 8'h72 && !sw_reset;
  endsequence
  // a second gain write in the lag cycle reaches the steps only one cycle after the clamp check
  sequence s_big_gain;
    reg_wr && reg_addr == 8'h7B && !sw_reset && !reg_wdata[7] &&
      reg_wdata > 8'h0C ##1 !sw_reset && !(reg_wr && reg_addr == 8'h7B);
  endsequence
  a_go_starts: assert property (s_go_wr ##0 reg_wdata[0] |=> decode_run)
    else $error("go write did not start decoding");
  a_go_stops: assert property (s_go_wr ##0 !reg_wdata[0] |=> !decode_run)
    else $error("go write of zero left decoding on");
  a_soft_idle: assert property (sw_reset |=>
    !decode_run && synth_fraction == 16'h5B46)
    else $error("soft reset left run or fraction wrong");
  a_sync_load: assert property (core_sync && !sw_reset |=>
    synth_fraction == $past(core_fraction))
    else $error("core fraction not loaded on sync");
  a_family_copy: assert property (
    !$past(rst) |-> synth_fraction_active == $past(core_family_48k))
    else $error("fraction active differs from family input");
  a_corner_low: assert property (
    reg_wr && reg_addr == 8'h77 && !sw_reset |=>
    high_shelf_corner[7:0] == $past(reg_wdata))
    else $error("treble corner low byte not written");
  a_corner_high: assert property (
    reg_wr && reg_addr == 8'h78 && !sw_reset |=>
    high_shelf_corner[15:8] == $past(reg_wdata))
    else $error("treble corner high byte not written");
  a_gain_range: assert property (
    !(high_shelf_steps inside {[8'h0D:8'hF3]}))
    else $error("treble steps outside twelve steps");
  a_gain_clamp: assert property (
    s_big_gain |=> high_shelf_steps == 8'h0C)
    else $error("large treble gain not saturated");
endmodule // dstr_regs_properties

bind dstr_regs dstr_regs_properties u_dstr_regs_properties (
  .mclk(mclk), .rst(rst), .sw_reset(sw_reset), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .core_sync(core_sync),
  .core_fraction(core_fraction), .core_family_48k(core_family_48k),
  .decode_run(decode_run), .synth_fraction(synth_fraction),
  .synth_fraction_active(synth_fraction_active),
  .high_shelf_corner(high_shelf_corner),
  .high_shelf_steps(high_shelf_steps)
);

// *** testbench/dstr_host.sv ***
// host model: byte writes and reads on the register port
// assumes one caller at a time; strobes last one mclk cycle
`timescale 1ns/100ps
module dstr_host (
  // clock
  input wire logic mclk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // idle data lines never echo the last byte
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
endmodule // dstr_host

// *** testbench/tb_dstr_regs.sv ***
// self-checking bench for the decoder status/tone register bank
// assumes the host model for register traffic; core side driven here
`timescale 1ns/100ps
module tb_dstr_regs import dstr_pkg::*; ();
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sw_reset = 1'b0;
  logic core_sync = 1'b0;
  logic [15:0] core_fraction = 16'h0000;
  logic core_family_48k = 1'b0;
  logic frame_done = 1'b0;
  logic [11:0] core_rate_x16 = 12'h000;
  logic boot_done = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, hs, ls, e;
  logic reg_wr, reg_rd, reg_rvalid, decode_run, synth_fraction_active;
  logic [15:0] synth_fraction, hc, lc, f;
  logic [11:0] r;
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'h9393a5b7;
  dstr_byte_t exp_q[$];
  dstr_byte_t wd[6];
  dstr_byte_t gi[8] = '{8'h20, 8'h0C, 8'h0D, 8'h7F,
                        8'hF4, 8'hF3, 8'h80, 8'hFF};
  dstr_byte_t go[8] = '{8'h0C, 8'h0C, 8'h0C, 8'h0C,
                        8'hF4, 8'hF4, 8'hF4, 8'hFF};
  always #2 mclk = ~mclk;
  dstr_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  dstr_regs #(.FW_REVISION(REV)) u_dstr_regs (.mclk(mclk), .rst(rst),
    .sw_reset(sw_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .core_sync(core_sync),
    .core_fraction(core_fraction), .core_family_48k(core_family_48k),
    .frame_done(frame_done), .core_rate_x16(core_rate_x16),
    .boot_done(boot_done), .decode_run(decode_run),
    .synth_fraction(synth_fraction),
    .synth_fraction_active(synth_fraction_active),
    .high_shelf_corner(hc), .low_shelf_corner(lc),
    .high_shelf_steps(hs), .low_shelf_steps(ls));
  task automatic chk(string n, logic [15:0] x, logic [15:0] s);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rdx(logic [7:0] a, logic [7:0] x);
    exp_q.push_back(x);
    host.rd(a);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // read data is looked at mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("spare read", 16'h0, 16'h1);
      else chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    chk("run time", 16'h0, 16'h1);
    stop_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 8'h64; a <= 8'h7C; a++) begin
      e = (a == 8'h65) ? 8'h5B : 8'h00;
      rdx(8'(a), e);
    end
    $display("reset values done");
    for (int i = 0; i < 6; i++) wd[i] = 8'($random(seed));
    wd[1] = (wd[1] & 8'h3F) | 8'h10;
    wd[2] = wd[2] | 8'h01;
    wd[3] = 8'h00;
    for (int i = 0; i < 6; i++) host.wr(8'(8'h77 + i), wd[i]);
    for (int i = 0; i < 6; i++) rdx(8'(8'h77 + i), wd[i]);
    chk("treble corner", {wd[1], wd[0]}, hc);
    chk("bass corner", {wd[3], wd[2]}, lc);
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h7B, gi[i]);
      host.wr(8'h7C, gi[7 - i]);
      repeat (2) @(negedge mclk);
      chk("treble steps", {8'h00, go[i]}, {8'h00, hs});
      chk("bass steps", {8'h00, go[7 - i]}, {8'h00, ls});
    end
    $display("tone test done");
    host.wr(8'h67, 8'hAA);
    host.wr(8'h6A, 8'h55);
    host.wr(8'h71, 8'h33);
    rdx(8'h67, 8'h00);
    rdx(8'h6A, 8'h00);
    rdx(8'h71, 8'h00);
    host.wr(8'h72, 8'hFF);
    @(negedge mclk);
    chk("decode run", 16'h1, {15'h0, decode_run});
    rdx(8'h72, 8'h01);
    host.wr(8'h72, 8'hFE);
    rdx(8'h72, 8'h00);
    $display("access test done");
    host.wr(8'h64, 8'h12);
    rdx(8'h64, 8'h12);
    f = 16'($random(seed));
    @(posedge mclk);
    core_fraction <= f;
    core_sync <= 1'b1;
    core_family_48k <= 1'b1;
    @(posedge mclk);
    core_sync <= 1'b0;
    core_fraction <= ~f;
    rdx(8'h64, f[7:0]);
    rdx(8'h65, f[15:8]);
    chk("fraction", f, synth_fraction);
    chk("family", 16'h1, {15'h0, synth_fraction_active});
    $display("fraction test done");
    @(posedge mclk);
    frame_done <= 1'b1;
    repeat (300) @(posedge mclk);
    frame_done <= 1'b0;
    rdx(8'h67, 8'h2C);
    rdx(8'h68, 8'h01);
    rdx(8'h69, 8'h00);
    host.wr(8'h72, 8'h01);
    @(posedge mclk);
    sw_reset <= 1'b1;
    @(posedge mclk);
    sw_reset <= 1'b0;
    for (int a = 8'h67; a <= 8'h69; a++) rdx(8'(a), 8'h00);
    rdx(8'h64, 8'h46);
    rdx(8'h72, 8'h00);
    rdx(8'h65, 8'h5B);
    $display("frame test done");
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 12'h008 : (i == 1) ? 12'hFF8 : 12'($random(seed));
      e = (r >= 12'hFF8) ? 8'hFF : 8'((r + 12'h008) >> 4);
      @(posedge mclk);
      core_rate_x16 <= r;
      repeat (2) @(posedge mclk);
      rdx(8'h6A, e);
    end
    $display("rate test done");
    rdx(8'h71, 8'h00);
    @(posedge mclk);
    boot_done <= 1'b1;
    @(posedge mclk);
    boot_done <= 1'b0;
    rdx(8'h71, REV);
    $display("boot test done");
    repeat (4) @(posedge mclk);
    chk("reads pending", 16'h0, 16'(exp_q.size()));
    stop_test();
  end
endmodule // tb_dstr_regs
